/* File: core/event_timers.v */
// Three 8-bit interval/event timers with their register file.
// Assumes a byte-wide register port from the processor core, a 125 MHz
// peripheral clock and a companion timer output on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "event_timers_regs.vh"

module event_timers (
	input wire clock,
	input wire rstn,
	input wire [15:0] reg_addr,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire event_input_pin,
	input wire gating_timer_output,
	input wire companion_timer_output,
	input wire capture_input_pin,
	input wire ext_interrupt_zero_pin,
	input wire serial_receive_first_pin,
	input wire serial_receive_alt_pin,
	input wire serial_transmit_line,
	output wire serial_transmit_first_pin,
	output wire serial_transmit_alt_pin,
	output wire serial_receive_line,
	output wire capture_input,
	output wire ext_interrupt_zero,
	output wire [2:0] match_interrupt,
	output reg timer_output
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	reg [2:0] clock_select_reg [0:2];
	reg [2:0] count_enable_reg;
	reg [7:0] compare_value_reg [0:2];
	reg inversion_enable_reg;
	reg [5:0] input_switch_reg;
	reg [`PRESCALE_WIDTH-1:0] prescale_reg;
	reg event_sync1_reg;
	reg event_sync2_reg;
	reg event_sync3_reg;
	reg event_level_reg;
	reg event_level_prev_reg;
	reg companion_prev_reg;
	wire [7:0] count_value [0:2];
	wire [2:0] count_tick;
	wire event_gated;
	wire event_rise;
	wire event_fall;
	wire companion_rise;
	wire [2:0] wr_mode;
	wire [2:0] wr_select;
	wire [2:0] wr_compare;
	wire wr_switch;

	// ****************************************************************
	// Address decode helpers
	// ****************************************************************
	// Mode control address of a timer
	function [15:0] mode_addr;
		input [1:0] idx;
		begin
			case (idx)
				`TIMER_FIRST: mode_addr = `ADDR_TIMER0_MODE_CONTROL;
				`TIMER_SECOND: mode_addr = `ADDR_TIMER1_MODE_CONTROL;
				default: mode_addr = `ADDR_TIMER2_MODE_CONTROL;
			endcase
		end
	endfunction

	// Clock select address of a timer
	function [15:0] select_addr;
		input [1:0] idx;
		begin
			case (idx)
				`TIMER_FIRST: select_addr = `ADDR_TIMER0_CLOCK_SELECT;
				`TIMER_SECOND: select_addr = `ADDR_TIMER1_CLOCK_SELECT;
				default: select_addr = `ADDR_TIMER2_CLOCK_SELECT;
			endcase
		end
	endfunction

	// Count value address of a timer
	function [15:0] count_addr;
		input [1:0] idx;
		begin
			case (idx)
				`TIMER_FIRST: count_addr = `ADDR_TIMER0_COUNT_VALUE;
				`TIMER_SECOND: count_addr = `ADDR_TIMER1_COUNT_VALUE;
				default: count_addr = `ADDR_TIMER2_COUNT_VALUE;
			endcase
		end
	endfunction

	// Compare value address of a timer
	function [15:0] compare_addr;
		input [1:0] idx;
		begin
			case (idx)
				`TIMER_FIRST: compare_addr = `ADDR_TIMER0_COMPARE_VALUE;
				`TIMER_SECOND: compare_addr = `ADDR_TIMER1_COMPARE_VALUE;
				default: compare_addr = `ADDR_TIMER2_COMPARE_VALUE;
			endcase
		end
	endfunction

	// ****************************************************************
	// Count clock selection
	// ****************************************************************
	// A divided clock "rises" when the low prescaler bits are all ones,
	// so every tap ticks once per period and all taps stay in phase
	function tick_select;
		input [1:0] idx;
		input [2:0] code;
		input [`PRESCALE_WIDTH-1:0] pre;
		input rise;
		input fall;
		input companion;
		begin
			case (code)
				`SEL_FULL: tick_select = 1'b1;
				`SEL_DIV2: tick_select = pre[`TAP_DIV2];
				`SEL_CODE4: tick_select = (idx == `TIMER_FIRST) ?
					(&pre[`TAP_DIV4:0]) : (&pre[`TAP_DIV16:0]);
				`SEL_DIV64: tick_select = &pre[`TAP_DIV64:0];
				`SEL_DIV256: tick_select = &pre[`TAP_DIV256:0];
				// Code 7 picks a different source on each timer
				`SEL_CODE7: begin
					if (idx == `TIMER_FIRST)
						tick_select = &pre[`TAP_DIV8192:0];
					else if (idx == `TIMER_SECOND)
						tick_select = companion;
					else
						tick_select = &pre[`TAP_DIV4096:0];
				end
				`SEL_EVENT_FALL: tick_select = (idx == `TIMER_THIRD) ? fall : 1'b0;
				`SEL_EVENT_RISE: tick_select = (idx == `TIMER_THIRD) ? rise : 1'b0;
				default: tick_select = 1'b0;
			endcase
		end
	endfunction

	// Free-running prescaler shared by all timers; never restarted by an
	// enable, so the first count after a start may come up to one period early
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			prescale_reg <= {`PRESCALE_WIDTH{1'b0}};
		else
			prescale_reg <= prescale_reg + `PRESCALE_ONE;
	end

	// ****************************************************************
	// Event input conditioning
	// ****************************************************************
	// Gate is applied before the synchroniser so a gated pulse never
	// half-enters the filter
	assign event_gated = event_input_pin &
		(~input_switch_reg[`SWITCH_EVENT_GATE] | gating_timer_output);

	// Three-stage synchroniser; level accepted once stages two and three agree
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			event_sync1_reg <= 1'b0;
			event_sync2_reg <= 1'b0;
			event_sync3_reg <= 1'b0;
			event_level_reg <= 1'b0;
			event_level_prev_reg <= 1'b0;
		end else begin
			event_sync1_reg <= event_gated;
			event_sync2_reg <= event_sync1_reg;
			event_sync3_reg <= event_sync2_reg;
			if (event_sync2_reg == event_sync3_reg)
				event_level_reg <= event_sync3_reg;
			event_level_prev_reg <= event_level_reg;
		end
	end

	// Edges come from the filtered level, so a count trails the pin by about five cycles
	assign event_rise = event_level_reg & ~event_level_prev_reg;
	assign event_fall = ~event_level_reg & event_level_prev_reg;

	// Companion output is same-clock logic, so only an edge detector;
	// a level held high counts once, not on every cycle
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			companion_prev_reg <= 1'b0;
		else
			companion_prev_reg <= companion_timer_output;
	end

	assign companion_rise = companion_timer_output & ~companion_prev_reg;

	// ****************************************************************
	// Timer channels
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : chan
			// Sized copy of the loop index, so the decoders get a two-bit argument
			localparam [1:0] chan_idx = g;
			assign wr_mode[g] = reg_write && (reg_addr == mode_addr(chan_idx));
			assign wr_select[g] = reg_write && (reg_addr == select_addr(chan_idx));
			assign wr_compare[g] = reg_write && (reg_addr == compare_addr(chan_idx));
			assign count_tick[g] = tick_select(chan_idx, clock_select_reg[g], prescale_reg,
				event_rise, event_fall, companion_rise);

			// Clock select and compare; whole-byte writes only, upper bits dropped
			always @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					clock_select_reg[g] <= `RESET_SEL;
					compare_value_reg[g] <= `RESET_BYTE;
					count_enable_reg[g] <= 1'b0;
				end else begin
					if (wr_select[g])
						clock_select_reg[g] <= reg_wdata[`SELECT_MSB:0];
					if (wr_compare[g])
						compare_value_reg[g] <= reg_wdata;
					if (wr_mode[g])
						count_enable_reg[g] <= reg_wdata[`MODE_COUNT_ENABLE];
				end
			end

			timer_channel counter (
				.clock(clock),
				.rstn(rstn),
				.count_enable_bit(count_enable_reg[g]),
				.count_tick(count_tick[g]),
				.compare_value(compare_value_reg[g]),
				.count_value(count_value[g]),
				.match_interrupt(match_interrupt[g])
			);
		end
	endgenerate

	// ****************************************************************
	// First timer output flip-flop
	// ****************************************************************
	// Set/clear act only on the write; the prohibited 11 pair is ignored
	// A set or clear write wins over a toggle that falls in the same cycle
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			inversion_enable_reg <= 1'b0;
			timer_output <= 1'b0;
		end else begin
			if (wr_mode[`TIMER_FIRST])
				inversion_enable_reg <= reg_wdata[`MODE_INVERSION_ENABLE];
			if (wr_mode[`TIMER_FIRST] &&
				(reg_wdata[`MODE_FLIPFLOP_SET] != reg_wdata[`MODE_FLIPFLOP_CLEAR]))
				timer_output <= reg_wdata[`MODE_FLIPFLOP_SET];
			else if (inversion_enable_reg && count_enable_reg[`TIMER_FIRST] &&
				match_interrupt[`TIMER_FIRST])
				timer_output <= ~timer_output;
		end
	end

	// ****************************************************************
	// Input switch and pin routing
	// ****************************************************************
	wire wr_switch_i;
	assign wr_switch_i = reg_write && (reg_addr == `ADDR_INPUT_SWITCH_CONTROL);
	assign wr_switch = wr_switch_i;

	// Only the six defined bits are stored; reserved bits read back as zero
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			input_switch_reg <= `RESET_SWITCH;
		else if (wr_switch)
			input_switch_reg <= reg_wdata[5:0];
	end

	// Alternate pair is chosen by the high select bit; 01 and 11 are
	// prohibited and fall to the first pair
	wire alt_pair;
	wire alt_receive;
	assign alt_pair = input_switch_reg[`SWITCH_SERIAL_HI] & ~input_switch_reg[`SWITCH_SERIAL_LO];
	assign alt_receive = serial_receive_alt_pin & input_switch_reg[`SWITCH_ALT_RECEIVE];
	assign serial_receive_line = alt_pair ? alt_receive : serial_receive_first_pin;
	// The unselected transmit pin idles high, like a released serial line
	assign serial_transmit_first_pin = alt_pair ? 1'b1 : serial_transmit_line;
	assign serial_transmit_alt_pin = alt_pair ? serial_transmit_line : 1'b1;
	assign capture_input = input_switch_reg[`SWITCH_CAPTURE_SOURCE] ?
		serial_receive_line : capture_input_pin;
	assign ext_interrupt_zero = input_switch_reg[`SWITCH_EXT_IRQ0_SOURCE] ?
		serial_receive_line : ext_interrupt_zero_pin;

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Read data is registered; unmapped addresses answer zero
	reg [7:0] read_next;
	integer i;
	always @* begin
		read_next = `RESET_BYTE;
		for (i = 0; i < 3; i = i + 1) begin
			if (reg_addr == mode_addr(i[1:0])) begin
				read_next[`MODE_COUNT_ENABLE] = count_enable_reg[i];
				if (i == 0)
					read_next[`MODE_INVERSION_ENABLE] = inversion_enable_reg;
			end
			if (reg_addr == select_addr(i[1:0]))
				read_next[`SELECT_MSB:0] = clock_select_reg[i];
			if (reg_addr == count_addr(i[1:0]))
				read_next = count_value[i];
			if (reg_addr == compare_addr(i[1:0]))
				read_next = compare_value_reg[i];
		end
		if (reg_addr == `ADDR_INPUT_SWITCH_CONTROL)
			read_next = {2'b00, input_switch_reg} & `SWITCH_USED_MASK;
	end

	// Read data holds until the next read strobe, so a slow master may take it late
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			reg_rdata <= `RESET_BYTE;
		else if (reg_read)
			reg_rdata <= read_next;
	end

endmodule
`default_nettype wire

/* File: shared/event_timers_regs.vh */
// Register map, field positions and clock codes of the three 8-bit timers.
// Included by the timer top and its counter channel; definitions only.
`ifndef EVENT_TIMERS_REGS_VH
`define EVENT_TIMERS_REGS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_TIMER1_MODE_CONTROL 16'hff43
`define ADDR_INPUT_SWITCH_CONTROL 16'hff4f
`define ADDR_TIMER2_CLOCK_SELECT 16'hff5b
`define ADDR_TIMER2_MODE_CONTROL 16'hff5c
`define ADDR_TIMER0_CLOCK_SELECT 16'hff6a
`define ADDR_TIMER0_MODE_CONTROL 16'hff6b
`define ADDR_TIMER1_CLOCK_SELECT 16'hff8c
// Count and compare registers, one pair per timer
`define ADDR_TIMER0_COUNT_VALUE 16'hff10
`define ADDR_TIMER0_COMPARE_VALUE 16'hff11
`define ADDR_TIMER1_COUNT_VALUE 16'hff12
`define ADDR_TIMER1_COMPARE_VALUE 16'hff13
`define ADDR_TIMER2_COUNT_VALUE 16'hff14
`define ADDR_TIMER2_COMPARE_VALUE 16'hff15

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define RESET_BYTE 8'h00
`define RESET_SEL 3'h0
`define COUNT_ZERO 8'h00
`define COUNT_ONE 8'h01
`define PRESCALE_WIDTH 13
`define PRESCALE_ONE 13'h0001
`define RESET_SWITCH 6'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define MODE_COUNT_ENABLE 7
`define MODE_FLIPFLOP_SET 3
`define MODE_FLIPFLOP_CLEAR 2
`define MODE_INVERSION_ENABLE 1
`define SWITCH_SERIAL_HI 5
`define SWITCH_SERIAL_LO 4
`define SWITCH_ALT_RECEIVE 3
`define SWITCH_EVENT_GATE 2
`define SWITCH_CAPTURE_SOURCE 1
`define SWITCH_EXT_IRQ0_SOURCE 0
`define SWITCH_USED_MASK 8'h3f

// ****************************************************************
// Clock select codes
// ****************************************************************
`define SEL_EVENT_FALL 3'h0
`define SEL_EVENT_RISE 3'h1
`define SEL_FULL 3'h2
`define SEL_DIV2 3'h3
`define SEL_CODE4 3'h4
`define SEL_DIV64 3'h5
`define SEL_DIV256 3'h6
`define SEL_CODE7 3'h7
`define SELECT_MSB 2

// ****************************************************************
// Prescaler taps: top bit of the all-ones window for each divider
// ****************************************************************
`define TAP_DIV2 0
`define TAP_DIV4 1
`define TAP_DIV16 3
`define TAP_DIV64 5
`define TAP_DIV256 7
`define TAP_DIV4096 11
`define TAP_DIV8192 12

// Timer index inside the channel array
`define TIMER_FIRST 2'h0
`define TIMER_SECOND 2'h1
`define TIMER_THIRD 2'h2

`endif

/* File: core/timer_channel.v */
// One 8-bit up-counter with compare-and-clear.
// Assumes a one-cycle count tick on the peripheral clock and an enable
// level straight from the mode control register.
`timescale 1ns/1ps
`default_nettype none
`include "event_timers_regs.vh"

module timer_channel (
	input wire clock,
	input wire rstn,
	input wire count_enable_bit,
	input wire count_tick,
	input wire [7:0] compare_value,
	output reg [7:0] count_value,
	output reg match_interrupt
);

	// ****************************************************************
	// Counter and match pulse
	// ****************************************************************
	// Compare is checked on every tick, so a compare of 00H fires every tick
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_value <= `COUNT_ZERO;
			match_interrupt <= 1'b0;
		end else if (!count_enable_bit) begin
			count_value <= `COUNT_ZERO;
			match_interrupt <= 1'b0;
		end else if (count_tick) begin
			if (count_value == compare_value) begin
				count_value <= `COUNT_ZERO;
				match_interrupt <= 1'b1;
			end else begin
				count_value <= count_value + `COUNT_ONE;
				match_interrupt <= 1'b0;
			end
		end else begin
			match_interrupt <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: tb/event_source.sv */
// Partner model: an external event pulse source on the event pin.
// Assumes the bench requests a burst with a one-cycle start strobe.
`timescale 1ns/1ps
`default_nettype none
module event_source (
	input wire logic clock,
	input wire logic start,
	input wire logic [7:0] pulses,
	output logic pin,
	output logic busy
);
	logic [7:0] left;
	logic [4:0] phase;
	initial begin
		pin = 1'b0;
		busy = 1'b0;
		left = 8'h00;
		phase = 5'h00;
	end
	// 16 high then 16 low: far wider than the pin filter, pin idles low
	always @(posedge clock) begin
		if (start) begin
			left <= pulses;
			phase <= 5'h00;
			busy <= 1'b1;
		end else if (busy) begin
			phase <= phase + 5'h01;
			pin <= !phase[4];
			if (phase == 5'h1f) begin
				left <= left - 8'h01;
				busy <= (left != 8'h01);
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/event_timers_assertions.sv */
// Port-level checker for the three 8-bit timers.
// Assumes byte writes taken on the rising edge; shadows switch and enables.
`timescale 1ns/1ps
`default_nettype none
module event_timers_checker (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [15:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic capture_input_pin,
	input wire logic ext_interrupt_zero_pin,
	input wire logic serial_receive_first_pin,
	input wire logic serial_receive_alt_pin,
	input wire logic serial_transmit_line,
	input wire logic serial_transmit_first_pin,
	input wire logic serial_transmit_alt_pin,
	input wire logic serial_receive_line,
	input wire logic capture_input,
	input wire logic ext_interrupt_zero,
	input wire logic [2:0] match_interrupt,
	input wire logic timer_output
);
	logic [7:0] switch_reg;
	logic [2:0] en_reg;
	logic inv_reg;
	logic wr_mode0;
	assign wr_mode0 = reg_write && reg_addr == 16'hff6b;
	// Shadow copies, so routing and enables can be judged from the ports
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			switch_reg <= 8'h00;
			en_reg <= 3'h0;
			inv_reg <= 1'b0;
		end else if (reg_write) begin
			if (reg_addr == 16'hff4f) switch_reg <= reg_wdata;
			if (reg_addr == 16'hff6b) inv_reg <= reg_wdata[1];
			if (reg_addr == 16'hff6b) en_reg[0] <= reg_wdata[7];
			if (reg_addr == 16'hff43) en_reg[1] <= reg_wdata[7];
			if (reg_addr == 16'hff5c) en_reg[2] <= reg_wdata[7];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_pair_write(logic [1:0] p);
		wr_mode0 && reg_wdata[3:2] == p;
	endsequence
	AST_IRQ_PULSE: assert property (|match_interrupt |=> (match_interrupt & $past(match_interrupt)) == 3'h0)
		else $error("match pulse wider than one cycle");
	AST_IRQ_ENABLED: assert property ((match_interrupt & ~$past(en_reg)) == 3'h0)
		else $error("match pulse while stopped");
	AST_PAIR_READ_ZERO: assert property (reg_read && reg_addr == 16'hff6b |=> reg_rdata[3:2] == 2'b00)
		else $error("set or clear bit read back");
	AST_SET_HIGH: assert property (s_pair_write(2'b10) |=> timer_output)
		else $error("output not set");
	AST_CLEAR_LOW: assert property (s_pair_write(2'b01) |=> !timer_output)
		else $error("output not cleared");
	AST_HOLD_LEVEL: assert property ($changed(timer_output) |->
		$past(wr_mode0) || ($past(match_interrupt[0]) && $past(inv_reg)))
		else $error("output changed without cause");
	AST_TX_FIRST: assert property (!switch_reg[5] |-> serial_transmit_first_pin == serial_transmit_line && serial_transmit_alt_pin)
		else $error("first transmit pin misrouted");
	AST_TX_ALT: assert property (switch_reg[5:4] == 2'b10 |-> serial_transmit_alt_pin == serial_transmit_line && serial_transmit_first_pin)
		else $error("alternate transmit pin misrouted");
	AST_RX_FIRST: assert property (!switch_reg[5] |-> serial_receive_line == serial_receive_first_pin)
		else $error("first receive pin misrouted");
	AST_RX_ALT: assert property (switch_reg[5:4] == 2'b10 |->
		serial_receive_line == (serial_receive_alt_pin && switch_reg[3]))
		else $error("alternate receive pin misrouted");
	AST_CAPTURE_SRC: assert property (capture_input == (switch_reg[1] ? serial_receive_line : capture_input_pin))
		else $error("capture source wrong");
	AST_IRQ0_SRC: assert property (ext_interrupt_zero == (switch_reg[0] ? serial_receive_line : ext_interrupt_zero_pin))
		else $error("interrupt zero source wrong");
endmodule
bind event_timers event_timers_checker chk (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_write(reg_write),
	.reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .capture_input_pin(capture_input_pin),
	.ext_interrupt_zero_pin(ext_interrupt_zero_pin), .serial_receive_first_pin(serial_receive_first_pin),
	.serial_receive_alt_pin(serial_receive_alt_pin), .serial_transmit_line(serial_transmit_line),
	.serial_transmit_first_pin(serial_transmit_first_pin), .serial_transmit_alt_pin(serial_transmit_alt_pin),
	.serial_receive_line(serial_receive_line), .capture_input(capture_input),
	.ext_interrupt_zero(ext_interrupt_zero), .match_interrupt(match_interrupt), .timer_output(timer_output));
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the three 8-bit timers.
// Assumes the byte register port and the event source partner model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
	logic clock = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, gating_timer_output = 1'b0;
	logic companion_timer_output = 1'b0, capture_input_pin = 1'b0, ext_interrupt_zero_pin = 1'b0;
	logic serial_receive_first_pin = 1'b0, serial_receive_alt_pin = 1'b0, serial_transmit_line = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00, ev_n = 8'h00, reg_rdata;
	logic [3:0] cc = 4'h0;
	logic ev_start = 1'b0, ev_pin, ev_busy, tx_first, tx_alt, rx_line, cap_in, irq0;
	logic [2:0] match_interrupt;
	logic timer_output;
	int err_total = 0, comparisons = 0;
	logic [15:0] sel_a [3] = '{16'hff6a, 16'hff8c, 16'hff5b};
	logic [15:0] mode_a [3] = '{16'hff6b, 16'hff43, 16'hff5c};
	logic [15:0] cmp_a [3] = '{16'hff11, 16'hff13, 16'hff15};
	event_timers dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_input_pin(ev_pin), .gating_timer_output(gating_timer_output),
		.companion_timer_output(companion_timer_output), .capture_input_pin(capture_input_pin),
		.ext_interrupt_zero_pin(ext_interrupt_zero_pin), .serial_receive_first_pin(serial_receive_first_pin),
		.serial_receive_alt_pin(serial_receive_alt_pin), .serial_transmit_line(serial_transmit_line),
		.serial_transmit_first_pin(tx_first), .serial_transmit_alt_pin(tx_alt), .serial_receive_line(rx_line),
		.capture_input(cap_in), .ext_interrupt_zero(irq0), .match_interrupt(match_interrupt), .timer_output(timer_output));
	event_source ev (.clock(clock), .start(ev_start), .pulses(ev_n), .pin(ev_pin), .busy(ev_busy));
	always #4 clock = ~clock;
	// Companion timer toggles every 5 cycles; pins wiggle so routing is exercised
	always @(posedge clock) begin
		cc <= (cc == 4'h9) ? 4'h0 : cc + 4'h1;
		companion_timer_output <= (cc < 4'h5);
		{serial_transmit_line, serial_receive_alt_pin, capture_input_pin, ext_interrupt_zero_pin} <= cc;
		serial_receive_first_pin <= ~cc[1];
	end
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Reset values, access kinds and the output flip-flop pair
	task automatic regs_check;
		logic [7:0] d;
		for (int i = 0; i < 3; i++) begin
			rd(sel_a[i], d); `CHK(d, 8'h00)
			rd(cmp_a[i], d); `CHK(d, 8'h00)
		end
		rd(16'hff00, d); `CHK(d, 8'h00)
		wr(16'hff11, 8'ha5); rd(16'hff11, d); `CHK(d, 8'ha5)
		wr(16'hff5b, 8'h05); rd(16'hff5b, d); `CHK(d, 8'h05)
		wr(16'hff10, 8'h55); rd(16'hff10, d); `CHK(d, 8'h00)
		wr(16'hff6b, 8'h02); wr(16'hff6b, 8'h0a); rd(16'hff6b, d); `CHK(d, 8'h02)
		`CHK(timer_output, 1'b1)
		wr(16'hff6b, 8'h0e); #1; `CHK(timer_output, 1'b1)
		wr(16'hff6b, 8'h06); #1; `CHK(timer_output, 1'b0)
		wr(16'hff4f, 8'h2f); rd(16'hff4f, d); `CHK(d, 8'h2f)
		repeat (12) @(posedge clock);
		wr(16'hff4f, 8'h27); rd(16'hff4f, d); `CHK(d, 8'h27)
		repeat (12) @(posedge clock);
		wr(16'hff4f, 8'h00);
	endtask
	// Stop, select clock, set compare, start; then time two match pulses
	task automatic period(input int t, input logic [2:0] code, input logic [7:0] cmp, input int exp);
		int n;
		wr(mode_a[t], 8'h00);
		wr(sel_a[t], {5'h00, code});
		wr(cmp_a[t], cmp);
		wr(mode_a[t], 8'h80);
		n = 0;
		while (match_interrupt[t] !== 1'b1 && n < 20000) begin @(posedge clock); #1; n++; end
		n = 0;
		do begin @(posedge clock); #1; n++; end while (match_interrupt[t] !== 1'b1 && n < 20000);
		`CHK(n, exp)
		wr(mode_a[t], 8'h00);
	endtask
	// Inversion on: the output flip-flop flips at each match
	task automatic toggle_check;
		wr(16'hff6b, 8'h02);
		wr(16'hff6b, 8'h06);
		period(0, 3'h2, 8'h03, 4);
		wr(16'hff6b, 8'h02);
		wr(16'hff6b, 8'h82);
		repeat (4) @(posedge clock);
		@(posedge match_interrupt[0]);
		repeat (2) @(posedge clock);
		`CHK(timer_output, 1'b1)
		@(posedge match_interrupt[0]);
		repeat (2) @(posedge clock);
		`CHK(timer_output, 1'b0)
		wr(16'hff6b, 8'h00);
	endtask
	// Third timer counts three event pulses through the optional gate
	task automatic events(input logic [7:0] sel, input logic gsel, input logic gate, input logic [7:0] exp);
		logic [7:0] d;
		int n;
		wr(16'hff5c, 8'h00);
		wr(16'hff5b, sel);
		wr(16'hff15, 8'hff);
		wr(16'hff4f, {5'h00, gsel, 2'h0});
		gating_timer_output <= gate;
		wr(16'hff5c, 8'h80);
		ev_n <= 8'h03;
		ev_start <= 1'b1;
		@(posedge clock);
		ev_start <= 1'b0;
		n = 0;
		do begin @(posedge clock); n++; end while (ev_busy === 1'b1 && n < 200);
		repeat (8) @(posedge clock);
		rd(16'hff14, d); `CHK(d, exp)
		wr(16'hff5c, 8'h00);
		rd(16'hff14, d); `CHK(d, 8'h00)
	endtask
	task automatic wrap_up;
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		regs_check();
		period(0, 3'h2, 8'h03, 4);
		period(0, 3'h2, 8'hff, 256);
		period(0, 3'h3, 8'h00, 2);
		period(0, 3'h4, 8'h00, 4);
		period(0, 3'h5, 8'h00, 64);
		period(0, 3'h6, 8'h00, 256);
		period(0, 3'h7, 8'h00, 8192);
		period(1, 3'h4, 8'h00, 16);
		period(1, 3'h7, 8'h00, 10);
		period(2, 3'h4, 8'h00, 16);
		period(2, 3'h7, 8'h00, 4096);
		toggle_check();
		events(8'h01, 1'b0, 1'b0, 8'h03);
		events(8'h00, 1'b0, 1'b0, 8'h03);
		events(8'h01, 1'b1, 1'b0, 8'h00);
		events(8'h01, 1'b1, 1'b1, 8'h03);
		wrap_up();
	end
endmodule
`default_nettype wire
